//--- core/rpfc_channel.sv
// One patch channel: holds a patch address and compares it with the fetch.
// Assumes the parent decodes register writes and supplies the enable bit.
`timescale 1ns/10ps
`default_nettype none
module rpfc_channel #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_value,
  input wire logic enable,
  input wire logic fetch_valid,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic [ADDR_W-1:0] patch_addr,
  output logic hit
);
  import rpfc_pkg::*;

  // Elaboration check: the reset constant holds at most 16 address bits.
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_width
    $error("rpfc_channel supports ADDR_W from 1 to 16 only.");
  end

  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;

  // ==========================================================================
  // Address register: a whole word per write, cleared on reset.
  always_comb begin
    addr_next = addr_reg;
    if (load) begin
      addr_next = load_value; // [RL5]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      addr_reg <= RPFC_RESET_PATCH_ADDRESS[ADDR_W-1:0]; // [RL6]
    end else begin
      addr_reg <= addr_next;
    end
  end

  // Full-width compare on every fetch, gated by this channel's enable only.
  assign hit = enable && fetch_valid && // [RL3] [RL13]
               (fetch_addr == addr_reg); // [RL14]
  assign patch_addr = addr_reg;

endmodule // rpfc_channel
`default_nettype wire

//--- core/rpfc_pkg.sv
// Package of constants and carriers for the fetch-address patch comparator.
// Assumes a 16-bit fetch address bus and a 16-bit special register bus.
package rpfc_pkg;

  // ==========================================================================
  // Register map, fields and reset values.
  localparam logic [15:0] RPFC_ADDR_PATCH_ADDRESS_0 = 16'hFF88;
  localparam logic [15:0] RPFC_ADDR_PATCH_ADDRESS_1 = 16'hFF8C;
  localparam logic [15:0] RPFC_ADDR_PATCH_CONTROL = 16'hFF8A;
  localparam int RPFC_BIT_HIT_FLAG_0 = 0;
  localparam int RPFC_BIT_ENABLE_0 = 1;
  localparam int RPFC_BIT_HIT_FLAG_1 = 2;
  localparam int RPFC_BIT_ENABLE_1 = 3;
  localparam logic [15:0] RPFC_RESET_PATCH_ADDRESS = 16'h0000;
  localparam logic [7:0] RPFC_RESET_PATCH_CONTROL = 8'h00;
  localparam logic [15:0] RPFC_REDIRECT_ADDRESS = 16'hF7FD;

  // ==========================================================================
  // Register bus request as seen by the block.
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic word_access;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rpfc_bus_req_t;

  // Branch request towards the fetch stage.
  typedef struct packed {
    logic req;
    logic [15:0] target;
  } rpfc_branch_t;

endpackage : rpfc_pkg

//--- core/rpfc_top.sv
// Fetch-address patch comparator with two channels and a control register.
// Assumes a synchronous CPU register bus and a fetch stage that accepts a
// registered branch request one cycle after the matching fetch address.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (RL1) Two independent patch channels exist, each with its own address.
// (RL2) A channel patches only while its enable bit (1 or 3) is set.
// (RL3) Every fetch is compared with both addresses without any trigger.
// (RL4) A match on an enabled channel requests a branch to F7FDH.
// (RL5) Each patch address is written whole by one 16-bit write.
// (RL6) Reset clears both patch addresses to 0000H.
// (RL7) Reset clears the control register to 00H, disabling both channels.
// (RL8) Software loads an address only while its enable bit is 0.
// (RL9) Software loads only the first opcode byte address of an instruction.
// (RL10) Software avoids addresses 0000H to 007FH.
// (RL11) Software may use either channel alone and leave the other off.
// (RL12) A match sets the hit flag (bit 0 or 2); writes can only clear it.
// (RL13) Each channel is gated only by its own enable bit.
// (RL14) The compare covers all 16 address bits.
module rpfc_top #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire rpfc_pkg::rpfc_bus_req_t bus_req,
  input wire logic fetch_valid,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output rpfc_pkg::rpfc_branch_t branch,
  output logic [15:0] bus_rdata
);
  import rpfc_pkg::*;

  // Elaboration check: the register map and redirect are 16-bit.
  if (ADDR_W != 16) begin : g_bad_width
    $error("rpfc_top supports only ADDR_W of 16.");
  end

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  rpfc_branch_t branch_reg;
  rpfc_branch_t branch_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [1:0] load;
  logic [1:0] hit;
  logic [1:0] enable;
  logic [ADDR_W-1:0] paddr [2];
  logic ctrl_wr;

  // ==========================================================================
  // Register decode.
  assign load[0] = bus_req.wr_en && bus_req.word_access &&
                   (bus_req.addr == RPFC_ADDR_PATCH_ADDRESS_0); // [RL5]
  assign load[1] = bus_req.wr_en && bus_req.word_access &&
                   (bus_req.addr == RPFC_ADDR_PATCH_ADDRESS_1); // [RL5]
  assign ctrl_wr = bus_req.wr_en && (bus_req.addr == RPFC_ADDR_PATCH_CONTROL);
  assign enable[0] = ctrl_reg[RPFC_BIT_ENABLE_0]; // [RL2]
  assign enable[1] = ctrl_reg[RPFC_BIT_ENABLE_1]; // [RL2]

  // Two identical channels, one per patch address register.
  for (genvar i = 0; i < 2; i++) begin : g_chan // [RL1]
    rpfc_channel #(.ADDR_W(ADDR_W)) u_chan (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .load(load[i]),
      .load_value(bus_req.wdata[ADDR_W-1:0]),
      .enable(enable[i]),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .patch_addr(paddr[i]),
      .hit(hit[i])
    );
  end

  // ==========================================================================
  // Control register: enables are writable, hit flags only set by hardware.
  // Software may write 0 to a flag to clear it; a hit in that cycle wins.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next[RPFC_BIT_ENABLE_0] = bus_req.wdata[RPFC_BIT_ENABLE_0];
      ctrl_next[RPFC_BIT_ENABLE_1] = bus_req.wdata[RPFC_BIT_ENABLE_1];
      ctrl_next[RPFC_BIT_HIT_FLAG_0] = ctrl_reg[RPFC_BIT_HIT_FLAG_0] &&
        bus_req.wdata[RPFC_BIT_HIT_FLAG_0]; // [RL12]
      ctrl_next[RPFC_BIT_HIT_FLAG_1] = ctrl_reg[RPFC_BIT_HIT_FLAG_1] &&
        bus_req.wdata[RPFC_BIT_HIT_FLAG_1]; // [RL12]
    end
    if (hit[0]) begin
      ctrl_next[RPFC_BIT_HIT_FLAG_0] = 1'b1; // [RL12]
    end
    if (hit[1]) begin
      ctrl_next[RPFC_BIT_HIT_FLAG_1] = 1'b1; // [RL12]
    end
    ctrl_next[7:4] = 4'h0;
  end

  // ==========================================================================
  // Branch request and read data, both registered.
  always_comb begin
    branch_next.req = |hit; // [RL4] [RL13]
    branch_next.target = RPFC_REDIRECT_ADDRESS; // [RL4]
    rdata_next = 16'h0000;
    if (bus_req.rd_en) begin
      case (bus_req.addr)
        RPFC_ADDR_PATCH_ADDRESS_0: rdata_next = paddr[0];
        RPFC_ADDR_PATCH_ADDRESS_1: rdata_next = paddr[1];
        RPFC_ADDR_PATCH_CONTROL: rdata_next = {8'h00, ctrl_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_reg <= RPFC_RESET_PATCH_CONTROL; // [RL7]
      branch_reg <= '0;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      branch_reg <= branch_next;
      rdata_reg <= rdata_next;
    end
  end

  assign branch = branch_reg;
  assign bus_rdata = rdata_reg;

  // ==========================================================================
  // Checks.
  property p_branch_on_hit;
    @(posedge sys_clk) disable iff (!reset_n)
      (fetch_valid && ctrl_reg[RPFC_BIT_ENABLE_0] &&
       fetch_addr == paddr[0]) |=> branch.req;
  endproperty
  a_branch_on_hit: assert property (p_branch_on_hit) // [RL4]
    else $error("Enabled match on channel 0 gave no branch.");

  property p_no_branch_disabled;
    @(posedge sys_clk) disable iff (!reset_n)
      (!ctrl_reg[RPFC_BIT_ENABLE_0] && !ctrl_reg[RPFC_BIT_ENABLE_1])
        |=> !branch.req;
  endproperty
  a_no_branch_disabled: assert property (p_no_branch_disabled) // [RL2]
    else $error("Branch raised with both channels disabled.");

  property p_target;
    @(posedge sys_clk) disable iff (!reset_n)
      branch.req |-> branch.target == RPFC_REDIRECT_ADDRESS;
  endproperty
  a_target: assert property (p_target) // [RL4]
    else $error("Branch target is not the redirect address.");

  property p_ch1_alone;
    @(posedge sys_clk) disable iff (!reset_n)
      (fetch_valid && ctrl_reg[RPFC_BIT_ENABLE_1] &&
       !ctrl_reg[RPFC_BIT_ENABLE_0] && fetch_addr == paddr[1])
        |=> branch.req && ctrl_reg[RPFC_BIT_HIT_FLAG_1];
  endproperty
  a_ch1_alone: assert property (p_ch1_alone) // [RL13]
    else $error("Channel 1 failed to act alone.");

  property p_flag_set;
    @(posedge sys_clk) disable iff (!reset_n)
      hit[0] |=> ctrl_reg[RPFC_BIT_HIT_FLAG_0];
  endproperty
  a_flag_set: assert property (p_flag_set) // [RL12]
    else $error("Hit flag 0 not set after match.");

  property p_flag_not_by_sw;
    @(posedge sys_clk) disable iff (!reset_n)
      (!ctrl_reg[RPFC_BIT_HIT_FLAG_1] && !hit[1])
        |=> !ctrl_reg[RPFC_BIT_HIT_FLAG_1];
  endproperty
  a_flag_not_by_sw: assert property (p_flag_not_by_sw) // [RL12]
    else $error("Hit flag 1 set without a match.");

  property p_load_word;
    @(posedge sys_clk) disable iff (!reset_n)
      load[1] |=> paddr[1] == $past(bus_req.wdata);
  endproperty
  a_load_word: assert property (p_load_word) // [RL5]
    else $error("Patch address 1 not loaded as a whole word.");

  property p_exact;
    @(posedge sys_clk) disable iff (!reset_n)
      (fetch_addr != paddr[0] && fetch_addr != paddr[1]) |=> !branch.req;
  endproperty
  a_exact: assert property (p_exact) // [RL14]
    else $error("Branch without an exact address match.");

  property p_ch0_alone;
    @(posedge sys_clk) disable iff (!reset_n)
      (fetch_valid && ctrl_reg[RPFC_BIT_ENABLE_0] &&
       !ctrl_reg[RPFC_BIT_ENABLE_1] && fetch_addr == paddr[0])
        |=> branch.req && ctrl_reg[RPFC_BIT_HIT_FLAG_0];
  endproperty
  a_ch0_alone: assert property (p_ch0_alone) // [RL13]
    else $error("Channel 0 failed to act alone.");

  property p_flag1_set;
    @(posedge sys_clk) disable iff (!reset_n)
      hit[1] |=> ctrl_reg[RPFC_BIT_HIT_FLAG_1];
  endproperty
  a_flag1_set: assert property (p_flag1_set) // [RL12]
    else $error("Hit flag 1 not set after match.");

  property p_flag0_not_by_sw;
    @(posedge sys_clk) disable iff (!reset_n)
      (!ctrl_reg[RPFC_BIT_HIT_FLAG_0] && !hit[0])
        |=> !ctrl_reg[RPFC_BIT_HIT_FLAG_0];
  endproperty
  a_flag0_not_by_sw: assert property (p_flag0_not_by_sw) // [RL12]
    else $error("Hit flag 0 set without a match.");

  // A byte-wide write must leave a patch address untouched.
  property p_load_refused;
    @(posedge sys_clk) disable iff (!reset_n)
      (bus_req.wr_en && !bus_req.word_access &&
       bus_req.addr == RPFC_ADDR_PATCH_ADDRESS_0) |=> $stable(paddr[0]);
  endproperty
  a_load_refused: assert property (p_load_refused) // [RL5]
    else $error("Patch address 0 changed on a byte-wide write.");

  property p_reset_clear;
    @(posedge sys_clk) !reset_n |=>
      ctrl_reg == RPFC_RESET_PATCH_CONTROL &&
      paddr[0] == RPFC_RESET_PATCH_ADDRESS &&
      paddr[1] == RPFC_RESET_PATCH_ADDRESS;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RL6] [RL7]
    else $error("Registers not cleared by reset.");

endmodule // rpfc_top
`default_nettype wire

//--- verification/rpfc_fetch_model.sv
// Behavioural model of the fetch stage that faces the patch comparator.
// Assumes the bench hands it one fetch address per cycle on cmd inputs.
`timescale 1ns/10ps
`default_nettype none
module rpfc_fetch_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_addr,
  input wire rpfc_pkg::rpfc_branch_t branch,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic [7:0] taken_count,
  output logic [15:0] taken_target
);
  import rpfc_pkg::*;
  // ==========================================================================
  // Fetch bus. Outside a fetch the address flips so stale values never match.
  assign fetch_valid = cmd_valid;
  assign fetch_addr = cmd_valid ? cmd_addr : ~cmd_addr;
  // ==========================================================================
  // Redirects are counted and their target kept, as the core would take them.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      taken_count <= 8'h00;
      taken_target <= 16'h0000;
    end else if (branch.req) begin
      taken_count <= taken_count + 8'h01;
      taken_target <= branch.target;
    end
  end
endmodule // rpfc_fetch_model
`default_nettype wire

//--- verification/rpfc_top_tb.sv
// Self-checking bench for the fetch-address patch comparator.
// Assumes the fetch model file is compiled before this one.
`timescale 1ns/10ps
`default_nettype none
module rpfc_top_tb;
  import rpfc_pkg::*;
  logic sys_clk;
  logic reset_n;
  rpfc_bus_req_t bus_req;
  logic cmd_valid;
  logic [15:0] cmd_addr;
  logic fetch_valid;
  logic [15:0] fetch_addr;
  rpfc_branch_t branch;
  logic [15:0] bus_rdata;
  logic [7:0] taken_count;
  logic [15:0] taken_target;
  logic [7:0] exp_taken;
  int err_count;
  int check_count;
  // ==========================================================================
  // Design and fetch stage model.
  rpfc_top #(.ADDR_W(16)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_req(bus_req), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .branch(branch), .bus_rdata(bus_rdata));
  rpfc_fetch_model fetch_stage (.sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .branch(branch),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .taken_count(taken_count), .taken_target(taken_target));
  // ==========================================================================
  // Clock of 8 ns.
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register write of one cycle.
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    bus_req <= '{1'h1, 1'h0, w, a, d};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  // One register read; data is looked at in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req <= '{1'h0, 1'h1, 1'h0, a, 16'h0000};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    check("register read", bus_rdata, exp);
  endtask
  // One fetch; the redirect count is checked once the request has landed.
  task automatic ft(input logic [15:0] a, input logic hit);
    @(posedge sys_clk);
    cmd_valid <= 1'h1;
    cmd_addr <= a;
    @(posedge sys_clk);
    cmd_valid <= 1'h0;
    @(posedge sys_clk);
    #1;
    exp_taken = exp_taken + {7'h00, hit};
    check("redirects", {8'h00, taken_count}, {8'h00, exp_taken});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the fewer than a hundred cycles the tests need.
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  // ==========================================================================
  // Test sequence.
  initial begin
    reset_n = 1'h0;
    bus_req = '0;
    cmd_valid = 1'h0;
    cmd_addr = 16'h0000;
    exp_taken = 8'h00;
    err_count = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    rd(RPFC_ADDR_PATCH_ADDRESS_0, 16'h0000);
    rd(RPFC_ADDR_PATCH_ADDRESS_1, 16'h0000);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h0000);
    rd(16'hFF00, 16'h0000);
    $display("test reset values done");
    wr(RPFC_ADDR_PATCH_ADDRESS_0, 16'h1000, 1'h1);
    ft(16'h1000, 1'h0);
    wr(RPFC_ADDR_PATCH_CONTROL, 16'h0002, 1'h1);
    ft(16'h1000, 1'h1);
    ft(16'h1000, 1'h1);
    check("target", taken_target, RPFC_REDIRECT_ADDRESS);
    ft(16'h1001, 1'h0);
    ft(16'h9000, 1'h0);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h0003);
    $display("test channel zero done");
    wr(RPFC_ADDR_PATCH_CONTROL, 16'h00FF, 1'h1);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h000B);
    wr(RPFC_ADDR_PATCH_CONTROL, 16'h00FA, 1'h1);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h000A);
    $display("test flag writes done");
    wr(RPFC_ADDR_PATCH_CONTROL, 16'h0000, 1'h1);
    wr(RPFC_ADDR_PATCH_ADDRESS_1, 16'h2000, 1'h1);
    wr(RPFC_ADDR_PATCH_ADDRESS_0, 16'h3333, 1'h0);
    rd(RPFC_ADDR_PATCH_ADDRESS_0, 16'h1000);
    rd(RPFC_ADDR_PATCH_ADDRESS_1, 16'h2000);
    wr(RPFC_ADDR_PATCH_CONTROL, 16'h0008, 1'h1);
    ft(16'h2000, 1'h1);
    ft(16'h1000, 1'h0);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h000C);
    $display("test channel one done");
    @(posedge sys_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    exp_taken = 8'h00;
    rd(RPFC_ADDR_PATCH_ADDRESS_1, 16'h0000);
    rd(RPFC_ADDR_PATCH_CONTROL, 16'h0000);
    ft(16'h0000, 1'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule // rpfc_top_tb
`default_nettype wire
